// ===== design/ofsr_pkg.sv
// package: constants and carrier types for the output fault status and recovery block
package ofsr_pkg;
  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] OFSR_ADDR_STATUS_BASE = 8'h00; // one status word per output, word i at 4*i
  localparam logic [7:0] OFSR_ADDR_CTRL        = 8'h40; // secondary re-enable request (write, pulse)
  localparam logic [7:0] OFSR_ADDR_SWITCH      = 8'h44; // switch enable state (read)
  localparam logic [7:0] OFSR_ADDR_LIMIT       = 8'h48; // end of register map, one past the switch register
  localparam int         OFSR_ADDR_W           = 8;

  // ==========================================================================
  // status word layout
  // ==========================================================================
  localparam int OFSR_BIT_OVERLOAD = 4;
  localparam int OFSR_BIT_BADMODE  = 5;
  localparam int OFSR_BIT_SAFEFAIL = 6;
  localparam int OFSR_BIT_SWOFF    = 7;
  localparam int OFSR_BIT_SUPPLY   = 8;

  localparam logic [1:0] OFSR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] OFSR_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int OFSR_CLK_MHZ     = 125;
  localparam int OFSR_HOLD_MS     = 250;
  localparam int OFSR_HOLD_CYCLES = OFSR_HOLD_MS * 1000 * OFSR_CLK_MHZ; // 31,250,000
  localparam int OFSR_CNT_W       = 25;

  // ==========================================================================
  // carriers
  // ==========================================================================
  typedef struct packed {
    logic overload;
    logic badMode;
    logic safeFail;
    logic swOff;
    logic supply;
  } ofsr_flags_t;

  // per-output supervisor state
  typedef enum logic [2:0] {
    OFSR_RUN   = 3'h1,
    OFSR_TRIP  = 3'h2,
    OFSR_ARMED = 3'h4
  } ofsr_ovl_t;
endpackage : ofsr_pkg

// ===== design/ofsr_hold_timer.sv
// module: one-output off-time timer, counts cycles a condition has held
`timescale 1ns/1ps
`default_nettype none
module ofsr_hold_timer
  import ofsr_pkg::*;
#(
  parameter int HOLD_CYCLES = OFSR_HOLD_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // condition
  input  wire logic holdActive,
  // result
  output logic      holdDone
);
  typedef struct packed {
    logic [OFSR_CNT_W-1:0] cnt;
    logic                  done;
  } ofsr_tmr_t;

  ofsr_tmr_t state_q;
  ofsr_tmr_t state_d;

  // ==========================================================================
  // counter: restarts whenever the condition drops
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    if (!holdActive) begin
      state_d.cnt  = '0;
      state_d.done = 1'b0;
    end else if (state_q.cnt >= OFSR_CNT_W'(HOLD_CYCLES - 1)) begin
      state_d.done = 1'b1; // saturate, no wrap
    end else begin
      state_d.cnt = state_q.cnt + OFSR_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign holdDone = state_q.done;
endmodule : ofsr_hold_timer
`default_nettype wire

// ===== design/ofsr_output_supervisor.sv
// module: per-output fault status and recovery supervisor with AXI4-Lite status access
// What this block does
// - overload sets bit 4, output disabled
// - after hold, clear bit 4, re-enable
// - invalid mode selection sets bit 5
// - valid mode selected clears bit 5
// - safety failure sets bit 6 until power-up
// - secondary switch-off sets bit 7
// - secondary re-enables after 250 ms, output off
// - supply out of range sets bit 8
// - bit 8 clears: all off, supply good
// - switch stays off 250 ms, requests ignored
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ofsr_output_supervisor
  import ofsr_pkg::*;
#(
  parameter int N_OUT       = 8,
  parameter int HOLD_CYCLES = OFSR_HOLD_CYCLES
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // axi4-lite write address / data / response
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // primary side, per output except the shared supplyOk (pins, synchronised)
  input  wire logic [N_OUT-1:0] cmdOff,
  input  wire logic [N_OUT-1:0] modeValid,
  input  wire logic [N_OUT-1:0] overloadDet,
  input  wire logic [N_OUT-1:0] safetyLayerFail,
  input  wire logic             supplyOk,
  // secondary side switch-off requests, per output
  input  wire logic [N_OUT-1:0] secSwitchOff,
  // drive
  output logic [N_OUT-1:0]      outputEnable,
  output logic [N_OUT-1:0]      redundantHighSideSwitch
);
  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [N_OUT-1:0] cmdOffS1, cmdOffS2, modeS1, modeS2, ovlS1, ovlS2, sfS1, sfS2, swS1, swS2;
    logic             supS1, supS2;
    ofsr_ovl_t [N_OUT-1:0] ovlSt;
    logic [N_OUT-1:0] fOvl, fMode, fSafe, fSw, fSup;
    logic [N_OUT-1:0] swOn;
    logic             wAddrHeld, wDataHeld;
    logic [7:0]       wAddr;
    logic [31:0]      wData;
    logic             bValid, rValid;
    logic [1:0]       bResp, rResp;
    logic [31:0]      rData;
  } ofsr_state_t;

  ofsr_state_t state_q;
  ofsr_state_t state_d;
  logic [N_OUT-1:0] ovlHoldDone;
  logic [N_OUT-1:0] swHoldDone;
  logic [N_OUT-1:0] reEnReq;

  // build the read word for one output; undefined bits stay zero
  function automatic logic [31:0] statusWord(input logic o, m, s, w, p);
    logic [31:0] v;
    v                    = '0;
    v[OFSR_BIT_OVERLOAD] = o;
    v[OFSR_BIT_BADMODE]  = m;
    v[OFSR_BIT_SAFEFAIL] = s;
    v[OFSR_BIT_SWOFF]    = w;
    v[OFSR_BIT_SUPPLY]   = p;
    return v;
  endfunction

  // ==========================================================================
  // off-time timers, one pair per output
  // ==========================================================================
  for (genvar i = 0; i < N_OUT; i++) begin : g_tmr
    ofsr_hold_timer #(.HOLD_CYCLES(HOLD_CYCLES)) u_ovl (
      .clk       (clk),
      .reset     (reset),
      .holdActive(state_q.ovlSt[i] != OFSR_RUN && state_q.cmdOffS2[i]),
      .holdDone  (ovlHoldDone[i])
    );
    ofsr_hold_timer #(.HOLD_CYCLES(HOLD_CYCLES)) u_sw (
      .clk       (clk),
      .reset     (reset),
      .holdActive(!state_q.swOn[i]),
      .holdDone  (swHoldDone[i])
    );
  end

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    logic        wFire;
    logic [7:0]  wa;
    logic [7:0]  ra;
    logic        allOff;
    state_d = state_q;
    wFire   = 1'b0;
    wa      = '0;
    ra      = '0;
    reEnReq = '0;
    allOff  = &state_q.cmdOffS2;
    // two-flop synchronisers on all primary and secondary pins, not the axi pins
    state_d.cmdOffS1 = cmdOff;      state_d.cmdOffS2 = state_q.cmdOffS1;
    state_d.modeS1   = modeValid;   state_d.modeS2   = state_q.modeS1;
    state_d.ovlS1    = overloadDet; state_d.ovlS2    = state_q.ovlS1;
    state_d.sfS1     = safetyLayerFail; state_d.sfS2 = state_q.sfS1;
    state_d.swS1     = secSwitchOff; state_d.swS2    = state_q.swS1;
    state_d.supS1    = supplyOk;    state_d.supS2    = state_q.supS1;

    // axi write: address and data captured in either order
    if (s_axi_awvalid && s_axi_awready) begin
      state_d.wAddrHeld = 1'b1;
      state_d.wAddr     = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      state_d.wDataHeld = 1'b1;
      state_d.wData     = s_axi_wdata;
    end
    if (state_q.wAddrHeld && state_q.wDataHeld && !state_q.bValid) begin
      wFire             = 1'b1;
      wa                = state_q.wAddr;
      state_d.wAddrHeld = 1'b0;
      state_d.wDataHeld = 1'b0;
      state_d.bValid    = 1'b1;
      state_d.bResp     = (wa == OFSR_ADDR_CTRL) ? OFSR_RESP_OKAY : OFSR_RESP_SLVERR;
    end
    if (state_q.bValid && s_axi_bready) state_d.bValid = 1'b0;
    if (wFire && wa == OFSR_ADDR_CTRL) reEnReq = state_q.wData[N_OUT-1:0];

    // per-output supervision
    for (int i = 0; i < N_OUT; i++) begin
      // overload: trip immediately, recover after off-time held
      case (state_q.ovlSt[i])
        OFSR_RUN:   if (state_q.ovlS2[i]) state_d.ovlSt[i] = OFSR_TRIP;
        OFSR_TRIP:  if (ovlHoldDone[i]) state_d.ovlSt[i] = OFSR_ARMED;
        OFSR_ARMED: state_d.ovlSt[i] = OFSR_RUN;
        default:    state_d.ovlSt[i] = OFSR_TRIP;
      endcase
      if (state_q.ovlSt[i] == OFSR_RUN && state_q.ovlS2[i]) state_d.fOvl[i] = 1'b1;
      else if (state_q.ovlSt[i] == OFSR_ARMED) state_d.fOvl[i] = 1'b0;
      // mode flag follows selection
      state_d.fMode[i] = !state_q.modeS2[i];
      // safety failure is sticky to power-up reset only
      if (state_q.sfS2[i]) state_d.fSafe[i] = 1'b1;
      // redundant switch: secondary cuts, re-enable only after hold and off command
      if (state_q.swS2[i]) begin
        state_d.swOn[i] = 1'b0;
        state_d.fSw[i]  = 1'b1;
      end else if (reEnReq[i] && !state_q.swOn[i] && swHoldDone[i] && state_q.cmdOffS2[i]) begin
        state_d.swOn[i] = 1'b1;
        state_d.fSw[i]  = 1'b0;
      end
      // supply: set wins over clear
      if (!state_q.supS2) state_d.fSup[i] = 1'b1;
      else if (allOff) state_d.fSup[i] = 1'b0;
    end

    // axi read
    if (s_axi_arvalid && s_axi_arready) begin
      ra             = s_axi_araddr;
      state_d.rValid = 1'b1;
      state_d.rResp  = OFSR_RESP_OKAY;
      state_d.rData  = '0;
      if (ra < OFSR_ADDR_LIMIT && ra[1:0] == 2'h0 && int'(ra[7:2]) < N_OUT) begin
        for (int i = 0; i < N_OUT; i++) begin
          if (int'(ra[7:2]) == i)
            state_d.rData = statusWord(state_q.fOvl[i], state_q.fMode[i], state_q.fSafe[i],
                                       state_q.fSw[i], state_q.fSup[i]);
        end
      end else if (ra == OFSR_ADDR_SWITCH) begin
        state_d.rData[N_OUT-1:0] = state_q.swOn;
      end else if (ra != OFSR_ADDR_CTRL) begin
        state_d.rResp = OFSR_RESP_SLVERR;
      end
    end else if (state_q.rValid && s_axi_rready) begin
      state_d.rValid = 1'b0;
    end
  end

  // ==========================================================================
  // registers: power-up reset zeroes them, except overload state RUN, switches on, supply and mode sync flops set
  // ==========================================================================
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q       <= '0;
      state_q.ovlSt <= {N_OUT{OFSR_RUN}};
      state_q.swOn  <= '1;
      state_q.supS1 <= 1'b1;
      state_q.supS2 <= 1'b1;
      state_q.modeS1 <= '1;
      state_q.modeS2 <= '1;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign s_axi_awready = !state_q.wAddrHeld;
  assign s_axi_wready  = !state_q.wDataHeld;
  assign s_axi_bvalid  = state_q.bValid;
  assign s_axi_bresp   = state_q.bResp;
  assign s_axi_arready = !state_q.rValid;
  assign s_axi_rvalid  = state_q.rValid;
  assign s_axi_rdata   = state_q.rData;
  assign s_axi_rresp   = state_q.rResp;
  // drive cut by overload, invalid mode, safety failure, or supply fault
  always_comb begin
    for (int i = 0; i < N_OUT; i++) begin
      outputEnable[i] = state_q.ovlSt[i] == OFSR_RUN && !state_q.fOvl[i] && !state_q.fSafe[i]
                        && !state_q.fSup[i] && !state_q.fMode[i];
    end
  end
  assign redundantHighSideSwitch = state_q.swOn;
endmodule : ofsr_output_supervisor
`default_nettype wire

// ===== tb/ofsr_checker.sv
// checker: port timing relations of the output supervisor
`timescale 1ns/1ps
`default_nettype none
module ofsr_checker #(
  parameter int N_OUT       = 8,
  parameter int HOLD_CYCLES = 20
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             reset,
  // register bus
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  // outputs and their causes
  input wire logic [N_OUT-1:0] cmdOff,
  input wire logic [N_OUT-1:0] overloadDet,
  input wire logic [N_OUT-1:0] secSwitchOff,
  input wire logic [N_OUT-1:0] outputEnable,
  input wire logic [N_OUT-1:0] redundantHighSideSwitch
);
  int offCnt_q;
  int cmdCnt_q;
  // ==========
  // off-time counters; cmdCnt_q uses the raw pin, so it runs ahead of the synchronised view
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      offCnt_q <= 0;
      cmdCnt_q <= 0;
    end else begin
      offCnt_q <= redundantHighSideSwitch[0] ? 0 : offCnt_q + 1;
      cmdCnt_q <= cmdOff[0] ? cmdCnt_q + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ovl_trip_a: assert property ($rose(overloadDet[0]) |-> ##3 !outputEnable[0])
    else $error("overload did not disable output");
  ovl_recover_a: assert property ($rose(outputEnable[0]) |-> cmdCnt_q >= HOLD_CYCLES)
    else $error("output enabled before off time");
  sw_cut_a: assert property ($rose(secSwitchOff[0]) |-> ##3 !redundantHighSideSwitch[0])
    else $error("switch not cut");
  sw_hold_a: assert property ($rose(redundantHighSideSwitch[0]) |-> offCnt_q >= HOLD_CYCLES)
    else $error("switch re-enabled early");
  undef_zero_a: assert property (s_axi_rvalid |->
      s_axi_rdata[31:9] == 0 && (s_axi_rdata[8:4] == 0 || s_axi_rdata[3:0] == 0))
    else $error("undefined status bits set");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
endmodule // ofsr_checker
bind ofsr_output_supervisor ofsr_checker #(.N_OUT(N_OUT), .HOLD_CYCLES(HOLD_CYCLES)) u_ofsr_checker (
  .clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .cmdOff, .overloadDet, .secSwitchOff, .outputEnable, .redundantHighSideSwitch);
`default_nettype wire

// ===== tb/ofsr_partner.sv
// partner: primary and secondary application logic at the output pins
`timescale 1ns/1ps
`default_nettype none
module ofsr_partner #(
  parameter int N_OUT = 2
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // bench requests
  input  wire logic             autoOff,
  input  wire logic [N_OUT-1:0] forceOff,
  input  wire logic [N_OUT-1:0] cutReq,
  // supervisor pins
  input  wire logic [N_OUT-1:0] outputEnable,
  output logic      [N_OUT-1:0] cmdOff,
  output logic      [N_OUT-1:0] secSwitchOff
);
  // with autoOff set, a disabled output stays commanded off until re-enabled, so the off
  // time can never fall short of the recovery wait
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmdOff       <= '0;
      secSwitchOff <= '0;
    end else begin
      cmdOff       <= forceOff | (autoOff ? ~outputEnable : '0);
      secSwitchOff <= cutReq;
    end
  end
endmodule // ofsr_partner
`default_nettype wire

// ===== tb/ofsr_output_supervisor_tb.sv
// testbench: fault flags and recovery of the output supervisor
`timescale 1ns/1ps
`default_nettype none
module ofsr_output_supervisor_tb
  import ofsr_pkg::*;
;
  localparam int N = 2;
  localparam int H = 20;
  localparam logic [31:0] OVL = 32'h1 << OFSR_BIT_OVERLOAD;
  localparam logic [31:0] BAD = 32'h1 << OFSR_BIT_BADMODE;
  localparam logic [31:0] SAF = 32'h1 << OFSR_BIT_SAFEFAIL;
  localparam logic [31:0] SWO = 32'h1 << OFSR_BIT_SWOFF;
  localparam logic [31:0] SUP = 32'h1 << OFSR_BIT_SUPPLY;
  localparam logic [1:0]  OK  = OFSR_RESP_OKAY;
  logic clk = 0, reset = 1, supplyOk = 1, autoOff = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [N-1:0] cmdOff, secSwitchOff, outputEnable, redundantHighSideSwitch;
  logic [N-1:0] modeValid = '1, overloadDet = '0, safetyLayerFail = '0, forceOff = '0, cutReq = '0;
  int num_errors = 0, checked = 0, cycleNum = 0;
  // ==========
  // clock and instances
  initial forever #4 clk = ~clk;
  always @(posedge clk) cycleNum <= cycleNum + 1;
  ofsr_output_supervisor #(.N_OUT(N), .HOLD_CYCLES(H)) u_ofsr_output_supervisor (
    .clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .cmdOff, .modeValid, .overloadDet, .safetyLayerFail, .supplyOk, .secSwitchOff,
    .outputEnable, .redundantHighSideSwitch);
  ofsr_partner #(.N_OUT(N)) u_ofsr_partner (
    .clk, .reset, .autoOff, .forceOff, .cutReq, .outputEnable, .cmdOff, .secSwitchOff);
  // ==========
  // shared tasks
  task automatic give_verdict();
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bound(input int n);
    if (n >= 200) begin
      num_errors++;
      give_verdict();
    end
  endtask
  // address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid  <= 1;
    s_axi_bready  <= 1;
    for (n = 0; n < 200 && !s_axi_bvalid; n++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end
    bound(n);
    check("bresp", 32'(er), 32'(s_axi_bresp));
    s_axi_bready <= 0;
    @(posedge clk); // one edge between release and the next request
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1;
    s_axi_rready  <= 1;
    for (n = 0; n < 200 && !s_axi_rvalid; n++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end
    bound(n);
    check("rdata", ed, s_axi_rdata);
    check("rresp", 32'(er), 32'(s_axi_rresp));
    s_axi_rready <= 0;
    @(posedge clk); // one edge between release and the next request
  endtask
  // ==========
  // scenarios
  task automatic t_idle();
    axi_rd(8'h04, '0, OK);
    axi_rd(OFSR_ADDR_SWITCH, 32'h3, OK);
    axi_rd(8'h80, '0, OFSR_RESP_SLVERR);
    axi_wr(8'h00, 32'hffff_ffff, OFSR_RESP_SLVERR);
  endtask
  task automatic t_overload();
    int n;
    int t0;
    t0 = cycleNum;
    autoOff <= 1;
    overloadDet[0] <= 1;
    repeat (4) @(posedge clk);
    check("enable", 32'h2, 32'(outputEnable));
    axi_rd(8'h00, OVL, OK);
    axi_rd(8'h04, '0, OK);
    overloadDet[0] <= 0;
    for (n = 0; n < 200 && outputEnable[0] !== 1'b1; n++) @(posedge clk);
    bound(n);
    check("recovery wait", 32'h1, 32'(cycleNum - t0 >= H));
    autoOff <= 0;
    axi_rd(8'h00, '0, OK);
  endtask
  task automatic t_mode();
    modeValid[1] <= 0;
    repeat (4) @(posedge clk);
    axi_rd(8'h04, BAD, OK);
    modeValid[1] <= 1;
    repeat (4) @(posedge clk);
    axi_rd(8'h04, '0, OK);
  endtask
  task automatic t_switch();
    cutReq[0] <= 1;
    repeat (5) @(posedge clk); // partner flop, two sync flops, then the switch register
    check("switch", 32'h2, 32'(redundantHighSideSwitch));
    axi_rd(8'h00, SWO, OK);
    cutReq[0] <= 0;
    forceOff[0] <= 1;
    repeat (4) @(posedge clk);
    axi_wr(OFSR_ADDR_CTRL, 32'h1, OK);
    repeat (4) @(posedge clk);
    axi_rd(OFSR_ADDR_SWITCH, 32'h2, OK);
    repeat (H) @(posedge clk);
    axi_wr(OFSR_ADDR_CTRL, 32'h1, OK);
    repeat (4) @(posedge clk);
    check("switch", 32'h3, 32'(redundantHighSideSwitch));
    axi_rd(8'h00, '0, OK);
    forceOff <= '0;
  endtask
  task automatic t_supply();
    supplyOk <= 0;
    repeat (4) @(posedge clk);
    axi_rd(8'h04, SUP, OK);
    supplyOk <= 1;
    forceOff <= 2'b01;
    repeat (H + 4) @(posedge clk);
    axi_rd(8'h00, SUP, OK);
    forceOff <= 2'b11;
    repeat (H + 4) @(posedge clk);
    axi_rd(8'h04, '0, OK);
  endtask
  task automatic t_safety();
    safetyLayerFail[1] <= 1;
    repeat (4) @(posedge clk);
    safetyLayerFail[1] <= 0;
    repeat (H + 4) @(posedge clk);
    axi_rd(8'h04, SAF, OK);
    axi_rd(8'h00, '0, OK);
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    t_idle();
    t_overload();
    t_mode();
    t_switch();
    t_supply();
    t_safety();
    give_verdict();
  end
endmodule // ofsr_output_supervisor_tb
`default_nettype wire
